// *** src/sgoc_fifo.sv ***
// sgoc_fifo: synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none

module sgoc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // fill and drain sides
  sgoc_stream_if.snk fillSide,
  sgoc_stream_if.src drainSide,
  // occupancy
  output logic [$clog2(DEPTH):0] level
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
  logic [AW:0] count_q, count_d;
  logic push, pop;

  assign fillSide.ready = (count_q != (AW+1)'(DEPTH));
  assign drainSide.valid = (count_q != '0);
  assign drainSide.data = mem[rdPtr_q];
  assign level = count_q;
  assign push = fillSide.valid && fillSide.ready;
  assign pop = drainSide.valid && drainSide.ready;

  always_comb begin
    wrPtr_d = wrPtr_q;
    rdPtr_d = rdPtr_q;
    count_d = count_q;
    if (push) begin
      wrPtr_d = wrPtr_q + 1'b1;
    end
    if (pop) begin
      rdPtr_d = rdPtr_q + 1'b1;
    end
    if (push && !pop) begin
      count_d = count_q + 1'b1;
    end else if (pop && !push) begin
      count_d = count_q - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      wrPtr_q <= wrPtr_d;
      rdPtr_q <= rdPtr_d;
      count_q <= count_d;
    end
  end

  // storage has no reset: sgoc_top loads drain data into its output register even while count is zero (with outValid low), so unwritten entries can be read
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_q] <= fillSide.data;
    end
  end

endmodule // sgoc_fifo

`default_nettype wire

// *** src/sgoc_pkg.sv ***
// sgoc_pkg: constants for the sample gain and offset correction block
package sgoc_pkg;

  // ---------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [5:0] SGOC_IDX_CFG = 6'h03;
  localparam logic [5:0] SGOC_IDX_CH11E = 6'h2a;
  localparam logic [5:0] SGOC_IDX_CH12O = 6'h2b;
  localparam logic [5:0] SGOC_IDX_CH12E = 6'h2c;
  localparam logic [5:0] SGOC_IDX_STATUS = 6'h3e;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int SGOC_GAIN_EN_BIT = 12;
  localparam int SGOC_OFFS_EN_BIT = 8;
  localparam int SGOC_RES_LSB = 0;
  localparam int SGOC_GAIN_MSB = 15;
  localparam int SGOC_GAIN_LSB = 11;
  localparam int SGOC_OFFS_MSB = 9;
  localparam int SGOC_OFFS_LSB = 0;
  localparam logic [15:0] SGOC_CORR_RESET = 16'h0000;
  localparam logic [15:0] SGOC_CFG_RESET = 16'h0000;

  // ---------------------------------------------------------------
  // streams, resolutions, datapath sizes
  // ---------------------------------------------------------------
  localparam int SGOC_NUM_STREAMS = 3;
  localparam logic [1:0] SGOC_STREAM_CH11E = 2'h0;
  localparam logic [1:0] SGOC_STREAM_CH12O = 2'h1;
  localparam logic [1:0] SGOC_STREAM_CH12E = 2'h2;
  localparam logic [1:0] SGOC_RES_14 = 2'h0;
  localparam logic [1:0] SGOC_RES_12 = 2'h1;
  localparam logic [1:0] SGOC_RES_10 = 2'h2;
  localparam int SGOC_SAMPLE_W = 14;
  localparam int SGOC_FIFO_W = 16;
  localparam int SGOC_FIFO_DEPTH = 32;
  localparam int SGOC_GAIN_FRAC = 14;
  localparam logic [16:0] SGOC_UNITY_GAIN = 17'h0_4000;
  localparam logic [32:0] SGOC_ROUND_HALF = 33'h0_0000_2000;

  // ---------------------------------------------------------------
  // gain multipliers: 10^(n*0.2/20) in unsigned q2.14
  // ---------------------------------------------------------------
  localparam logic [15:0] SGOC_GAIN_LUT [0:31] = '{
    16'h4000, 16'h417E, 16'h4304, 16'h4494, 16'h462D, 16'h47CF, 16'h497B, 16'h4B32,
    16'h4CF2, 16'h4EBD, 16'h5092, 16'h5273, 16'h545E, 16'h5655, 16'h5858, 16'h5A67,
    16'h5C82, 16'h5EAA, 16'h60DE, 16'h6320, 16'h656F, 16'h67CC, 16'h6A37, 16'h6CB0,
    16'h6F38, 16'h71CF, 16'h7476, 16'h772D, 16'h79F3, 16'h7CCA, 16'h7FB2, 16'h82AC};

endpackage

// *** src/sgoc_stream_if.sv ***
// sgoc_stream_if: valid/ready word carrier between the block's modules
`timescale 1ns/1ps
`default_nettype none

interface sgoc_stream_if #(parameter int WIDTH = 16);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

`default_nettype wire

// *** src/sgoc_top.sv ***
// sgoc_top: per-stream digital gain and offset correction with wishbone registers
//
// Contract
// - gain applied only while global gain enable set
// - gain code N gives N times 0.2 dB
// - offset subtracted only while global offset enable set
// - offset is 10-bit signed, 14-bit lsb units
// - register 0x2a corrects channel 11 even stream
// - register 0x2b corrects channel 12 odd stream
// - register 0x2c corrects channel 12 even, independent
//
// The Wishbone register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module sgoc_top
  import sgoc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // wishbone classic slave
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [7:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatW,
  output logic [31:0] wbDatR,
  output logic wbAck,
  // raw sample stream in
  input wire logic sampleValid,
  input wire logic [1:0] sampleStream,
  input wire logic [SGOC_SAMPLE_W-1:0] sampleData,
  output logic sampleReady,
  // corrected sample stream out
  output logic outValid,
  output logic [1:0] outStream,
  output logic [SGOC_SAMPLE_W-1:0] outData,
  input wire logic outReady
);

  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------
  logic [15:0] corr_q [SGOC_NUM_STREAMS];
  logic [15:0] corr_d [SGOC_NUM_STREAMS];
  logic [15:0] cfg_q, cfg_d;
  logic wbAck_q, wbAck_d;
  logic [31:0] wbDatR_q, wbDatR_d;
  logic [5:0] regIdx;
  logic busReq;
  logic [5:0] fifoLevel;
  logic busy;

  assign regIdx = wbAdr[7:2];
  assign busReq = wbCyc && wbStb && !wbAck_q;

  // byte-lane merge of a 16-bit register
  function automatic logic [15:0] sgoc_merge(input logic [15:0] old, input logic [31:0] wdat,
                                             input logic [3:0] sel);
    logic [15:0] res;
    res = old;
    if (sel[0]) begin
      res[7:0] = wdat[7:0];
    end
    if (sel[1]) begin
      res[15:8] = wdat[15:8];
    end
    return res;
  endfunction

  // each correction register has its own index and feeds only its stream
  genvar gi;
  generate
    for (gi = 0; gi < SGOC_NUM_STREAMS; gi++) begin : gCorr
      localparam logic [5:0] IDX = SGOC_IDX_CH11E + 6'(gi);
      always_comb begin
        corr_d[gi] = corr_q[gi];
        if (busReq && wbWe && regIdx == IDX) begin
          corr_d[gi] = sgoc_merge(corr_q[gi], wbDatW, wbSel);
        end
      end
      always_ff @(posedge clk) begin
        if (!resetn) begin
          corr_q[gi] <= SGOC_CORR_RESET;
        end else begin
          corr_q[gi] <= corr_d[gi];
        end
      end
    end
  endgenerate

  always_comb begin
    cfg_d = cfg_q;
    wbAck_d = busReq;
    wbDatR_d = 32'h0000_0000;
    if (busReq && wbWe && regIdx == SGOC_IDX_CFG) begin
      cfg_d = sgoc_merge(cfg_q, wbDatW, wbSel);
    end
    // unmapped indices still ack, reading zero and ignoring writes
    if (busReq && !wbWe) begin
      case (regIdx)
        SGOC_IDX_CFG: wbDatR_d = {16'h0000, cfg_q};
        SGOC_IDX_CH11E: wbDatR_d = {16'h0000, corr_q[0]};
        SGOC_IDX_CH12O: wbDatR_d = {16'h0000, corr_q[1]};
        SGOC_IDX_CH12E: wbDatR_d = {16'h0000, corr_q[2]};
        SGOC_IDX_STATUS: wbDatR_d = {24'h00_0000, 1'b0, busy, fifoLevel};
        default: wbDatR_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      cfg_q <= SGOC_CFG_RESET;
      wbAck_q <= 1'b0;
      wbDatR_q <= 32'h0000_0000;
    end else begin
      cfg_q <= cfg_d;
      wbAck_q <= wbAck_d;
      wbDatR_q <= wbDatR_d;
    end
  end

  assign wbAck = wbAck_q;
  assign wbDatR = wbDatR_q;

  // ---------------------------------------------------------------
  // stage 1: align, pick stream settings, subtract offset
  // ---------------------------------------------------------------
  logic gainEn, offsEn;
  logic [1:0] resMode;
  logic [2:0] alignShift;
  logic accept;
  logic sampleReady_q, sampleReady_d;
  logic [15:0] selReg;
  logic signed [15:0] aligned;
  logic signed [15:0] offsExt;
  logic s1Valid_q, s1Valid_d;
  logic [1:0] s1Stream_q, s1Stream_d;
  logic [2:0] s1Shift_q, s1Shift_d;
  logic signed [15:0] s1Diff_q, s1Diff_d;
  logic [16:0] s1Gain_q, s1Gain_d;

  assign gainEn = cfg_q[SGOC_GAIN_EN_BIT];
  assign offsEn = cfg_q[SGOC_OFFS_EN_BIT];
  assign resMode = cfg_q[SGOC_RES_LSB +: 2];
  assign accept = sampleValid && sampleReady_q;

  always_comb begin
    case (resMode)
      SGOC_RES_12: alignShift = 3'd2;
      SGOC_RES_10: alignShift = 3'd4;
      default: alignShift = 3'd0;
    endcase
    case (sampleStream)
      SGOC_STREAM_CH11E: selReg = corr_q[0];
      SGOC_STREAM_CH12O: selReg = corr_q[1];
      SGOC_STREAM_CH12E: selReg = corr_q[2];
      default: selReg = 16'h0000;
    endcase
    // low-resolution samples are lifted to 14-bit weight so the offset lsb stays a 14-bit lsb
    aligned = 16'(signed'({{2{sampleData[SGOC_SAMPLE_W-1]}}, sampleData}) <<< alignShift);
    offsExt = 16'(signed'(selReg[SGOC_OFFS_MSB:SGOC_OFFS_LSB]));
    s1Valid_d = accept;
    s1Stream_d = sampleStream;
    s1Shift_d = alignShift;
    s1Diff_d = offsEn ? 16'(aligned - offsExt) : aligned;
    s1Gain_d = gainEn ? {1'b0, SGOC_GAIN_LUT[selReg[SGOC_GAIN_MSB:SGOC_GAIN_LSB]]}
                      : SGOC_UNITY_GAIN;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s1Valid_q <= 1'b0;
      s1Stream_q <= 2'h0;
      s1Shift_q <= 3'h0;
      s1Diff_q <= 16'h0000;
      s1Gain_q <= SGOC_UNITY_GAIN;
    end else begin
      s1Valid_q <= s1Valid_d;
      s1Stream_q <= s1Stream_d;
      s1Shift_q <= s1Shift_d;
      s1Diff_q <= s1Diff_d;
      s1Gain_q <= s1Gain_d;
    end
  end

  // ---------------------------------------------------------------
  // stage 2: multiply, round, saturate, return to resolution
  // ---------------------------------------------------------------
  logic signed [32:0] product;
  logic signed [32:0] rounded;
  logic signed [18:0] scaled;
  logic signed [13:0] clipped;
  logic s2Valid_q, s2Valid_d;
  logic [1:0] s2Stream_q, s2Stream_d;
  logic [SGOC_SAMPLE_W-1:0] s2Data_q, s2Data_d;

  always_comb begin
    product = 33'(s1Diff_q * signed'(s1Gain_q));
    rounded = product + signed'(SGOC_ROUND_HALF);
    scaled = 19'(rounded >>> SGOC_GAIN_FRAC);
    // clip rather than wrap: up to 6.2 dB of gain can overrange a full-scale input
    if (scaled > 19'sd8191) begin
      clipped = 14'sd8191;
    end else if (scaled < -19'sd8192) begin
      clipped = -14'sd8192;
    end else begin
      clipped = 14'(scaled);
    end
    s2Valid_d = s1Valid_q;
    s2Stream_d = s1Stream_q;
    s2Data_d = 14'(clipped >>> s1Shift_q);
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s2Valid_q <= 1'b0;
      s2Stream_q <= 2'h0;
      s2Data_q <= '0;
    end else begin
      s2Valid_q <= s2Valid_d;
      s2Stream_q <= s2Stream_d;
      s2Data_q <= s2Data_d;
    end
  end

  // ---------------------------------------------------------------
  // output fifo and back-pressure
  // ---------------------------------------------------------------
  sgoc_stream_if #(.WIDTH(SGOC_FIFO_W)) fillBus ();
  sgoc_stream_if #(.WIDTH(SGOC_FIFO_W)) drainBus ();

  assign fillBus.valid = s2Valid_q;
  assign fillBus.data = {s2Stream_q, s2Data_q};

  sgoc_fifo #(
    .WIDTH(SGOC_FIFO_W),
    .DEPTH(SGOC_FIFO_DEPTH)
  ) uFifo (
    .clk(clk),
    .resetn(resetn),
    .fillSide(fillBus.snk),
    .drainSide(drainBus.src),
    .level(fifoLevel)
  );

  logic [6:0] committed;
  logic outValid_q, outValid_d;
  logic [1:0] outStream_q, outStream_d;
  logic [SGOC_SAMPLE_W-1:0] outData_q, outData_d;
  logic outLoad;

  assign busy = s1Valid_q || s2Valid_q || outValid_q;
  assign outLoad = !outValid_q || outReady;
  assign drainBus.ready = outLoad;

  always_comb begin
    // count everything in flight so the pipeline never meets a full fifo
    committed = 7'(fifoLevel) + 7'(s1Valid_q) + 7'(s2Valid_q) + 7'(accept);
    sampleReady_d = committed < 7'(SGOC_FIFO_DEPTH);
    outValid_d = outValid_q;
    outStream_d = outStream_q;
    outData_d = outData_q;
    if (outLoad) begin
      outValid_d = drainBus.valid;
      outStream_d = drainBus.data[SGOC_FIFO_W-1 -: 2];
      outData_d = drainBus.data[SGOC_SAMPLE_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      sampleReady_q <= 1'b0;
      outValid_q <= 1'b0;
      outStream_q <= 2'h0;
      outData_q <= '0;
    end else begin
      sampleReady_q <= sampleReady_d;
      outValid_q <= outValid_d;
      outStream_q <= outStream_d;
      outData_q <= outData_d;
    end
  end

  assign sampleReady = sampleReady_q;
  assign outValid = outValid_q;
  assign outStream = outStream_q;
  assign outData = outData_q;

endmodule // sgoc_top

`default_nettype wire

// *** verification/sgoc_top_monitor.sv ***
// sgoc_top_monitor: bus and stream timing assertions for sgoc_top
`timescale 1ns/1ps
`default_nettype none

module sgoc_top_monitor
  import sgoc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // wishbone
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic [31:0] wbDatR,
  input wire logic wbAck,
  // streams
  input wire logic sampleValid,
  input wire logic sampleReady,
  input wire logic outValid,
  input wire logic [1:0] outStream,
  input wire logic [SGOC_SAMPLE_W-1:0] outData,
  input wire logic outReady
);
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  ack_timing_a: assert property (wbCyc && wbStb && !wbAck |=> wbAck)
    else $error("bus request not answered in the next cycle");
  ack_pulse_a: assert property (wbAck |=> !wbAck)
    else $error("bus ack longer than one cycle");
  rdat_idle_a: assert property (!wbAck |-> wbDatR == 32'h0000_0000)
    else $error("read data not zero outside ack");
  rdat_upper_a: assert property (wbAck |-> wbDatR[31:16] == 16'h0000)
    else $error("read data upper lanes not zero");
  // output must not change while the sink stalls
  out_hold_a: assert property (outValid && !outReady |=> outValid && $stable(outData) && $stable(outStream))
    else $error("output changed under back-pressure");
  out_latency_a: assert property (sampleValid && sampleReady && !outValid |-> ##[1:4] outValid)
    else $error("sample not delivered within four cycles");
  reset_quiet_a: assert property (resetn && !$past(resetn) |-> !outValid && !wbAck && !sampleReady)
    else $error("outputs active at first edge after reset");
  ready_rise_a: assert property (resetn && !$past(resetn) |=> sampleReady)
    else $error("input not ready after reset");
endmodule // sgoc_top_monitor

bind sgoc_top sgoc_top_monitor mon (
  .clk(clk), .resetn(resetn), .wbCyc(wbCyc), .wbStb(wbStb), .wbDatR(wbDatR), .wbAck(wbAck),
  .sampleValid(sampleValid), .sampleReady(sampleReady), .outValid(outValid),
  .outStream(outStream), .outData(outData), .outReady(outReady)
);

`default_nettype wire

// *** verification/sgoc_top_tb.sv ***
// sgoc_top_tb: self-checking bench for the gain and offset correction block
`timescale 1ns/1ps
`default_nettype none

module sgoc_top_tb
  import sgoc_pkg::*;
;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic clk = 0, resetn = 0, wbCyc = 0, wbStb = 0, wbWe = 0, sampleValid = 0, outReady = 0, stall = 0;
  logic [7:0] wbAdr = 8'h00;
  logic [3:0] wbSel = 4'h0;
  logic [31:0] wbDatW = 32'h0000_0000, wbDatR, seed = 32'h0000_1b98;
  logic [1:0] sampleStream = 2'h0, outStream;
  logic [13:0] sampleData = 14'h0000, outData;
  logic wbAck, sampleReady, outValid;
  logic [15:0] regs [0:2] = '{default: 16'h0000};
  logic [15:0] cfg = 16'h0000;
  logic [32:0] acc;
  logic [32:0] accQ [$];
  logic [15:0] outQ [$];
  int errors = 0, samples_checked = 0;

  always #4 clk = ~clk;

  sgoc_top dut (.clk(clk), .resetn(resetn), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
    .wbAdr(wbAdr), .wbSel(wbSel), .wbDatW(wbDatW), .wbDatR(wbDatR), .wbAck(wbAck),
    .sampleValid(sampleValid), .sampleStream(sampleStream), .sampleData(sampleData),
    .sampleReady(sampleReady), .outValid(outValid), .outStream(outStream), .outData(outData),
    .outReady(outReady));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function logic [31:0] rnd();
    seed = {seed[30:0], ^(seed & 32'h8020_0003)};
    return seed;
  endfunction

  function int sh();
    return (cfg[1:0] == 2'h1) ? 2 : (cfg[1:0] == 2'h2) ? 4 : 0;
  endfunction

  function automatic logic [15:0] model(input logic [1:0] st, input logic [13:0] dt);
    logic [15:0] r;
    logic signed [15:0] d;
    logic signed [33:0] p;
    r = (st == 2'h3) ? 16'h0000 : regs[st];
    d = $signed(dt) <<< sh();
    if (cfg[SGOC_OFFS_EN_BIT]) d = d - $signed(r[9:0]);
    p = d * $signed({1'b0, cfg[SGOC_GAIN_EN_BIT] ? SGOC_GAIN_LUT[r[15:11]] : 16'h4000}) + 8192;
    p = p >>> 14;
    if (p > 8191) p = 8191;
    if (p < -8192) p = -8192;
    p = p >>> sh();
    return {st, p[13:0]};
  endfunction

  task check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task wb(input logic we, input logic [7:0] adr, input logic [3:0] sel, input logic [31:0] dat);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbSel <= sel;
    wbDatW <= dat;
    accQ.push_back({~we, dat});
    @(posedge clk);
    while (wbAck !== 1'b1) @(posedge clk);
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge clk);
  endtask

  // back to back samples, random streams including the uncorrected one
  task send(input int n);
    logic [31:0] r;
    for (int i = 0; i < n; i++) begin
      r = rnd();
      sampleValid <= 1'b1;
      sampleStream <= r[15:14];
      sampleData <= 14'($signed(r[13:0]) >>> sh());
      @(posedge clk);
      while (sampleReady !== 1'b1) @(posedge clk);
      outQ.push_back(model(sampleStream, sampleData));
    end
    sampleValid <= 1'b0;
    @(posedge clk);
  endtask

  task report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    outReady <= !stall && (rnd() % 4 != 0);
    if (wbAck === 1'b1 && accQ.size() > 0) begin
      acc = accQ.pop_front();
      if (acc[32]) check("read data", acc[31:0], wbDatR);
    end
    if (outValid === 1'b1 && outReady === 1'b1) begin
      if (outQ.size() > 0) check("sample", outQ.pop_front(), {outStream, outData});
      else check("unexpected sample", 32'h0000_0000, 32'h0000_0001);
    end
  end

  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    report_and_stop();
  end

  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    for (int a = 0; a < 4; a++) wb(1'b0, 8'hA8 + 8'(4 * a), 4'hF, 32'h0000_0000);
    wb(1'b0, 8'h0C, 4'hF, 32'h0000_0000);
    wb(1'b0, 8'hF8, 4'hF, 32'h0000_0000);
    // unmapped place swallows writes
    wb(1'b1, 8'hB4, 4'hF, 32'h0000_FFFF);
    wb(1'b0, 8'hB4, 4'hF, 32'h0000_0000);
    for (int a = 0; a < 3; a++) begin
      regs[a] = 16'(rnd()) & 16'hFBFF;
      wb(1'b1, 8'hA8 + 8'(4 * a), 4'h3, {16'h0000, regs[a]});
    end
    regs[2][7:0] = 8'h5A;
    wb(1'b1, 8'hB0, 4'h1, 32'h0000_A55A);
    for (int a = 0; a < 3; a++) wb(1'b0, 8'hA8 + 8'(4 * a), 4'hF, {16'h0000, regs[a]});
    // every gain code (odd codes with gain on), both enables, every resolution
    for (int k = 0; k < 32; k++) begin
      cfg = {3'h0, k[0], 3'h0, k[1], 6'h00, k[3:2]};
      regs[0] = {5'(k), 1'b0, 10'(rnd())};
      regs[1] = 16'(rnd()) & 16'hFBFF;
      regs[2] = 16'(rnd()) & 16'hFBFF;
      wb(1'b1, 8'h0C, 4'h3, {16'h0000, cfg});
      for (int a = 0; a < 3; a++) wb(1'b1, 8'hA8 + 8'(4 * a), 4'h3, {16'h0000, regs[a]});
      send(6);
    end
    // fill the buffer until the input refuses, then drain with stalls
    stall <= 1'b1;
    fork
      send(40);
      begin
        for (int t = 0; t < 300 && sampleReady === 1'b1; t++) @(posedge clk);
        check("input ready when full", 32'h0000_0000, {31'h0, sampleReady});
        // two more edges let the last accepted sample land in the fifo
        repeat (2) @(posedge clk);
        wb(1'b0, 8'hF8, 4'hF, 32'h0000_0060);
        stall <= 1'b0;
      end
    join
    for (int t = 0; t < 1000 && outQ.size() > 0; t++) @(posedge clk);
    check("left over samples", 32'h0000_0000, outQ.size());
    repeat (4) @(posedge clk);
    wb(1'b0, 8'hF8, 4'hF, 32'h0000_0000);
    // reset again mid-run: the correction, unmapped and config registers must read back zero (status is not read)
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    for (int a = 0; a < 4; a++) wb(1'b0, 8'hA8 + 8'(4 * a), 4'hF, 32'h0000_0000);
    wb(1'b0, 8'h0C, 4'hF, 32'h0000_0000);
    report_and_stop();
  end
endmodule // sgoc_top_tb

`default_nettype wire
